/* File: include/slmc_defines.svh */
// Register offsets, field positions and reset values of the link and converter control bank.
// Assumes it is included once per compilation unit by its bare name.
`ifndef SLMC_DEFINES_SVH
`define SLMC_DEFINES_SVH

// ******************************************
// Register offsets
// ******************************************
`define SLMC_OFS_LOCK_STATE 12'h250
`define SLMC_OFS_LINK_RESET 12'h253
`define SLMC_OFS_EXT_REF 12'h2b0
`define SLMC_OFS_CUR_DBL 12'h2b1
`define SLMC_OFS_OFS_HOLD 12'h2cf

// ******************************************
// Field positions and reset values
// ******************************************
`define SLMC_LIVE_LSB 4
`define SLMC_LOST_LSB 0
`define SLMC_CTRL_RESET 8'h00

`endif

/* File: include/slmc_pkg.sv */
// Types shared by the link and converter control bank.
// Assumes nothing beyond a SystemVerilog compiler.
package slmc_pkg;
	// Register access request from the serial control port.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} slmc_req_t;

	// Control levels that steer the analog and link logic.
	typedef struct packed {
		logic link_logic_reset_bit;
		logic external_reference_enable;
		logic current_doubler_enable;
		logic offset_update_hold_bit;
	} slmc_ctrl_t;

	// Capture states of the lane arrival values.
	typedef enum logic [1:0] {
		SLMC_ARMED = 2'b01,
		SLMC_TAKEN = 2'b10
	} slmc_cap_t;
endpackage

/* File: rtl/slmc_regs.sv */
// Control and status register bank for the serializer link and converter options.
// Assumes a decoded serial control port access on clk, asynchronous lock inputs,
// and a high-speed domain that samples the offset apply strobe.
`include "slmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module slmc_regs #(
	parameter int PLLS = 4,
	parameter int OFS_W = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Register access.
	input wire slmc_pkg::slmc_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Serializer PLL lock indications, asynchronous.
	input wire logic [PLLS-1:0] pll_lock,
	// Elastic buffer release attempt, same clock.
	input wire logic release_try,
	output logic arrival_capture,
	// Offset values written elsewhere, and what the DACs use.
	input wire logic [OFS_W-1:0] pending_ofs_a,
	input wire logic [OFS_W-1:0] pending_ofs_b,
	output logic [OFS_W-1:0] per_dac_offset_value_a,
	output logic [OFS_W-1:0] per_dac_offset_value_b,
	output logic ofs_apply,
	// Control levels.
	output slmc_pkg::slmc_ctrl_t ctrl
);
	import slmc_pkg::*;

	// Refuse sizes that the read layout and the lane group mapping cannot serve.
	if (PLLS != 4) begin : g_bad_plls
		$error("slmc_regs serves exactly four PLLs");
	end
	if (OFS_W < 1) begin : g_bad_width
		$error("slmc_regs needs a positive offset width");
	end

	// ******************************************
	// Lock input synchronisers
	// ******************************************
	logic [PLLS-1:0] lock_s1, lock_s2, lock_s3, live_lock_bits;

	// A bit moves only when the second and third stages agree, so one metastable
	// sample cannot make a short false loss of lock.
	wire [PLLS-1:0] next_live = (lock_s2 & lock_s3) | (live_lock_bits & (lock_s2 | lock_s3));

	// Three stages; the live value changes once the second and third agree.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lock_s1 <= '0;
			lock_s2 <= '0;
			lock_s3 <= '0;
			live_lock_bits <= '0;
		end else begin
			lock_s1 <= pll_lock;
			lock_s2 <= lock_s1;
			lock_s3 <= lock_s2;
			live_lock_bits <= next_live;
		end
	end

	// ******************************************
	// Decode
	// ******************************************
	wire wr_lock = req.wr && req.addr == `SLMC_OFS_LOCK_STATE;
	wire wr_rst = req.wr && req.addr == `SLMC_OFS_LINK_RESET;
	wire wr_ext = req.wr && req.addr == `SLMC_OFS_EXT_REF;
	wire wr_dbl = req.wr && req.addr == `SLMC_OFS_CUR_DBL;
	wire wr_hold = req.wr && req.addr == `SLMC_OFS_OFS_HOLD;

	// ******************************************
	// Sticky lock-lost bits
	// ******************************************
	logic [PLLS-1:0] lock_lost;
	// Bit n covers lanes 4n to 4n+3; a set in the clearing cycle wins.
	wire [PLLS-1:0] lost_clr = wr_lock ? req.wdata[`SLMC_LOST_LSB +: PLLS] : '0;
	wire [PLLS-1:0] next_lost = (lock_lost & ~lost_clr) | ~live_lock_bits;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lock_lost <= '0;
		end else begin
			lock_lost <= next_lost;
		end
	end

	// ******************************************
	// Control registers, full bytes kept as read/write
	// ******************************************
	logic [7:0] rst_reg, ext_reg, dbl_reg, hold_reg;

	// Reserved bits are plain storage and read back what was written.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_reg <= `SLMC_CTRL_RESET;
			ext_reg <= `SLMC_CTRL_RESET;
			dbl_reg <= `SLMC_CTRL_RESET;
			hold_reg <= `SLMC_CTRL_RESET;
		end else begin
			if (wr_rst) rst_reg <= req.wdata;
			if (wr_ext) ext_reg <= req.wdata;
			if (wr_dbl) dbl_reg <= req.wdata;
			if (wr_hold) hold_reg <= req.wdata;
		end
	end

	// Control levels go out registered, one cycle after the byte.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= '0;
		end else begin
			ctrl.link_logic_reset_bit <= rst_reg[0];
			ctrl.external_reference_enable <= ext_reg[0];
			ctrl.current_doubler_enable <= dbl_reg[0];
			ctrl.offset_update_hold_bit <= hold_reg[0];
		end
	end

	// ******************************************
	// Offset hold and apply
	// ******************************************
	logic hold_d;
	wire hold_fall = hold_d && !hold_reg[0];

	// Outside hold the offsets follow; under hold they freeze; on release both load at once.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hold_d <= 1'b0;
			per_dac_offset_value_a <= '0;
			per_dac_offset_value_b <= '0;
			ofs_apply <= 1'b0;
		end else begin
			hold_d <= hold_reg[0];
			ofs_apply <= hold_fall;
			if (!hold_reg[0]) begin
				per_dac_offset_value_a <= pending_ofs_a;
				per_dac_offset_value_b <= pending_ofs_b;
			end
		end
	end

	// ******************************************
	// Lane arrival capture, once per reset
	// ******************************************
	slmc_cap_t cap_state;
	// Link logic under reset makes no release attempt.
	wire first_try = cap_state == SLMC_ARMED && release_try && !ctrl.link_logic_reset_bit;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cap_state <= SLMC_ARMED;
			arrival_capture <= 1'b0;
		end else begin
			arrival_capture <= first_try;
			unique case (cap_state)
				SLMC_ARMED: if (first_try) cap_state <= SLMC_TAKEN;
				SLMC_TAKEN: cap_state <= SLMC_TAKEN;
				default: cap_state <= SLMC_ARMED;
			endcase
		end
	end

	// ******************************************
	// Read path
	// ******************************************
	logic [7:0] rd_mux;
	always_comb begin
		unique case (req.addr)
			`SLMC_OFS_LOCK_STATE: rd_mux = {live_lock_bits, lock_lost};
			`SLMC_OFS_LINK_RESET: rd_mux = rst_reg;
			`SLMC_OFS_EXT_REF: rd_mux = ext_reg;
			`SLMC_OFS_CUR_DBL: rd_mux = dbl_reg;
			`SLMC_OFS_OFS_HOLD: rd_mux = hold_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data is registered one cycle after the request.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd) rdata <= rd_mux;
		end
	end

	// ******************************************
	// Checks
	// ******************************************
	// Every PLL seen unlocked has its lost bit set on the next cycle.
	a_lost_sets: assert property (@(posedge clk) disable iff (!resetn)
		|(~live_lock_bits) |=> (lock_lost & ~$past(live_lock_bits)) == ~$past(live_lock_bits))
		else $error("lost bit not set");

	// Without a clearing write no lost bit falls.
	a_lost_sticky: assert property (@(posedge clk) disable iff (!resetn)
		(|lock_lost && !wr_lock) |=> (lock_lost & $past(lock_lost)) == $past(lock_lost))
		else $error("lost bit dropped");

	// A write of ones clears those bits unless the PLL is still unlocked.
	a_lost_clears: assert property (@(posedge clk) disable iff (!resetn)
		wr_lock |=> (lock_lost & $past(req.wdata[`SLMC_LOST_LSB +: PLLS] & live_lock_bits)) == '0)
		else $error("lost bit not cleared");

	// A write of zeros leaves the lost bits alone.
	a_zero_keeps: assert property (@(posedge clk) disable iff (!resetn)
		(wr_lock && req.wdata[3:0] == 4'h0) |=> (lock_lost & $past(lock_lost)) == $past(lock_lost))
		else $error("zero write cleared");

	// Once both late stages agree the live bits take their value.
	a_live_sync: assert property (@(posedge clk) disable iff (!resetn)
		(lock_s2 == lock_s3) |=> live_lock_bits == $past(lock_s2))
		else $error("live lock not synchronised");

	// The status read shows the live bits of the taking cycle.
	a_live_read: assert property (@(posedge clk) disable iff (!resetn)
		(req.rd && req.addr == `SLMC_OFS_LOCK_STATE) |=> rdata[7:4] == $past(live_lock_bits))
		else $error("live field wrong");

	// Read valid is a one-cycle echo of the read strobe.
	a_read_valid: assert property (@(posedge clk) disable iff (!resetn)
		1'b1 |=> rvalid == $past(req.rd))
		else $error("read valid wrong");

	// Link reset level follows the written bit two cycles later.
	a_rst_out: assert property (@(posedge clk) disable iff (!resetn)
		wr_rst |=> ##1 ctrl.link_logic_reset_bit == $past(req.wdata[0], 2))
		else $error("link reset not driven");

	// External reference level follows the written bit two cycles later.
	a_ext_out: assert property (@(posedge clk) disable iff (!resetn)
		wr_ext |=> ##1 ctrl.external_reference_enable == $past(req.wdata[0], 2))
		else $error("ext ref wrong");

	// Doubler level follows the written bit two cycles later.
	a_dbl_out: assert property (@(posedge clk) disable iff (!resetn)
		wr_dbl |=> ##1 ctrl.current_doubler_enable == $past(req.wdata[0], 2))
		else $error("doubler wrong");

	// Hold level follows the written bit two cycles later.
	a_hold_out: assert property (@(posedge clk) disable iff (!resetn)
		wr_hold |=> ##1 ctrl.offset_update_hold_bit == $past(req.wdata[0], 2))
		else $error("hold level wrong");

	// Under hold neither DAC offset moves.
	a_hold_freeze: assert property (@(posedge clk) disable iff (!resetn)
		hold_reg[0] |=> $stable(per_dac_offset_value_a) && $stable(per_dac_offset_value_b))
		else $error("offset moved in hold");

	// Leaving hold loads both offsets in one cycle and pulses the apply strobe.
	a_apply_both: assert property (@(posedge clk) disable iff (!resetn)
		$fell(hold_reg[0]) |=> per_dac_offset_value_a == $past(pending_ofs_a) &&
			per_dac_offset_value_b == $past(pending_ofs_b) && ofs_apply)
		else $error("offsets not applied together");

	// The apply strobe comes only from a falling hold bit.
	a_apply_cause: assert property (@(posedge clk) disable iff (!resetn)
		ofs_apply |-> $past(hold_reg[0], 2) && !$past(hold_reg[0]))
		else $error("apply without release");

	// The first accepted release attempt captures and disarms.
	a_capture_first: assert property (@(posedge clk) disable iff (!resetn)
		first_try |=> arrival_capture && cap_state == SLMC_TAKEN)
		else $error("first capture missed");

	// Link logic held in reset makes no capture.
	a_reset_gate: assert property (@(posedge clk) disable iff (!resetn)
		ctrl.link_logic_reset_bit |=> !arrival_capture)
		else $error("capture under link reset");

	// After the capture no later attempt captures again.
	a_capture_once: assert property (@(posedge clk) disable iff (!resetn)
		cap_state == SLMC_TAKEN |-> ##1 !arrival_capture)
		else $error("second capture");

endmodule

`default_nettype wire

/* File: tb/test_slmc_regs.sv */
// Self-checking bench for the link and converter control bank.
// Assumes slmc_pkg is compiled first and slmc_defines.svh is on the include path.
`include "slmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module test_slmc_regs;
	import slmc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	slmc_req_t req = '0;
	logic [7:0] rdata;
	logic rvalid;
	logic arrival_capture;
	logic ofs_apply;
	logic [3:0] pll_lock = 4'h0;
	logic release_try = 1'b0;
	logic [15:0] pa = 16'h0000;
	logic [15:0] pb = 16'h0000;
	logic [15:0] da;
	logic [15:0] db;
	slmc_ctrl_t ctrl;
	int fail_count = 0;
	int samples_checked = 0;
	int n;
	logic [11:0] ofs [4] = '{`SLMC_OFS_LINK_RESET, `SLMC_OFS_EXT_REF, `SLMC_OFS_CUR_DBL,
		`SLMC_OFS_OFS_HOLD};
	localparam logic [11:0] LK = `SLMC_OFS_LOCK_STATE;

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	slmc_regs DUT (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
		.pll_lock(pll_lock), .release_try(release_try), .arrival_capture(arrival_capture),
		.pending_ofs_a(pa), .pending_ofs_b(pb), .per_dac_offset_value_a(da), .per_dac_offset_value_b(db),
		.ofs_apply(ofs_apply), .ctrl(ctrl));

	// Compares one result and counts it.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	// Write strobe lasts one cycle, launched at a falling edge.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req <= '0;
	endtask

	// Read data and its valid pulse are checked in the cycle after the taking edge.
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge clk);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req <= '0;
		chk({8'h00, rdata}, {8'h00, e});
		chk({15'h0000, rvalid}, 16'h0001);
	endtask

	// One release attempt; reports whether a capture pulse followed.
	task automatic try_release(input logic e);
		logic hit;
		hit = 1'b0;
		@(negedge clk);
		release_try = 1'b1;
		repeat (4) begin
			@(negedge clk);
			release_try = 1'b0;
			hit = hit | (arrival_capture === 1'b1);
		end
		chk({15'h0000, hit}, {15'h0000, e});
	endtask

	task automatic end_sim();
		$display("Compared %0d, mismatched %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence: status, controls, link reset, capture, offset hold.
	initial begin
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		cyc(8);
		rd(LK, 8'h0f);
		for (int i = 0; i < 4; i++) rd(ofs[i], 8'h00);
		rd(12'h251, 8'h00);
		pll_lock = 4'hf;
		cyc(8);
		rd(LK, 8'hff);
		wr(LK, 8'h05);
		rd(LK, 8'hfa);
		wr(LK, 8'h00);
		rd(LK, 8'hfa);
		wr(LK, 8'h0a);
		rd(LK, 8'hf0);
		for (int i = 0; i < 4; i++) begin
			pll_lock = ~(4'h1 << i);
			cyc(5);
			pll_lock = 4'hf;
			cyc(8);
			rd(LK, 8'hf0 | (8'h01 << i));
			wr(LK, 8'h01 << i);
		end
		wr(12'h251, 8'hff);
		for (int i = 0; i < 4; i++) begin
			wr(ofs[i], 8'ha5);
			cyc(2);
			chk({12'h000, ctrl}, 16'h0001 << (3 - i));
			rd(ofs[i], 8'ha5);
			wr(ofs[i], 8'h00);
		end
		wr(ofs[0], 8'h01);
		cyc(2);
		try_release(1'b0);
		wr(ofs[0], 8'h00);
		cyc(2);
		try_release(1'b1);
		try_release(1'b0);
		pa = 16'h1234;
		pb = 16'h5678;
		cyc(3);
		wr(ofs[3], 8'h01);
		cyc(2);
		pa = 16'hbeef;
		pb = 16'hcafe;
		cyc(4);
		chk(da, 16'h1234);
		chk(db, 16'h5678);
		wr(ofs[3], 8'h00);
		n = 0;
		while (ofs_apply !== 1'b1 && n < 5) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, ofs_apply}, 16'h0001);
		chk(da, 16'hbeef);
		chk(db, 16'hcafe);
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		cyc(4);
		try_release(1'b1);
		end_sim();
	end

	// Cuts a hang short well after the sequence should have ended.
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end
endmodule

`default_nettype wire
